// *** core/ssp_core.v ***
// Serial control port and mode-control pins of a high-side switch controller.
// Assumes serial pins and control inputs arrive asynchronously and are
// oversampled by clk at 250 MHz; serial clock stays at or below 5 MHz.
// What this block does
// - Chip select high: serial clock and data are ignored.
// - Frame starts on chip select low, completes on its return high.
// - Serial input captured on rising serial clock.
// - Serial output changes on falling serial clock.
// - Serial output released whenever chip select is high.
// - Serial output carries shifted bits onward for a daisy chain.
// - Frames are 16 bits; serial clock at most 5 MHz.
// - Reset restores configuration and fault state and enters sleep.
// - Any direct input activity wakes the device.
// - In Fail mode each direct input drives its own channel.
// - In Normal mode serial settings decide direct input effect.
// - Limp input active forces Fail mode.
// - Communication loss enters Fail mode, direct inputs still control.
// - Clock pin reports sleep state by being driven low; released when awake.
// - Reference clock on clock pin divided by 256 for PWM timebase in Normal mode only.
// - External switch output is a logic on/off command.
// - Open-drain sense sync tells master when to start conversion.
// - Serial setting selects current, temperature or supply on sense output.
`timescale 1ns/1ns
`include "ssp_defines.vh"

module ssp_core
(
  input wire clk,
  input wire nrst,
  input wire reset_sleep_n,
  input wire chip_select_n,
  input wire sclk,
  input wire si,
  output reg so_o,
  output reg so_oe,
  input wire direct_in_1,
  input wire direct_in_2,
  input wire direct_in_3,
  input wire direct_in_4,
  input wire limp_in,
  input wire clk_pin_i,
  output reg clk_pin_o,
  output reg clk_pin_oe,
  output reg [3:0] chan_on,
  output reg ext_switch_out,
  output reg [2:0] sense_out,
  output reg sense_sync_o,
  output reg sense_sync_oe,
  output reg pwm_tick,
  output reg fail_mode,
  output reg sleep_state
);

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  wire [9:0] pins_s;
  ssp_sync2 #(.W(10)) u_sync
  (
    .clk(clk),
    .nrst(nrst),
    // Select enters inverted so the bank's reset value reads as deselected
    .d({clk_pin_i, limp_in, direct_in_4, direct_in_3, direct_in_2, direct_in_1,
        si, sclk, ~chip_select_n, reset_sleep_n}),
    .q(pins_s)
  );
  wire rst_pin_n = pins_s[0];
  wire cs_n = ~pins_s[1];
  wire sck = pins_s[2];
  wire sdi = pins_s[3];
  wire [3:0] din = pins_s[7:4];
  wire limp = pins_s[8];
  wire refclk = pins_s[9];

  // ***********************************************
  // Edge helpers
  // ***********************************************
  // Shared by the select, serial clock and reference paths
  function edge_up;
    input prev;
    input cur;
    begin
      edge_up = ~prev & cur;
    end
  endfunction

  function edge_down;
    input prev;
    input cur;
    begin
      edge_down = prev & ~cur;
    end
  endfunction

  // ***********************************************
  // Edge detection on synchronised pins
  // ***********************************************
  reg cs_d_r;
  reg sck_d_r;
  reg [3:0] din_d_r;
  reg ref_d_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b0;
      din_d_r <= 4'h0;
      ref_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r <= cs_n;
      sck_d_r <= sck;
      din_d_r <= din;
      ref_d_r <= refclk;
    end
  end
  wire cs_fall = edge_down(cs_d_r, cs_n);
  wire cs_rise = edge_up(cs_d_r, cs_n);
  // Edges only count inside a frame
  wire sck_rise = ~cs_n & edge_up(sck_d_r, sck);
  wire sck_fall = ~cs_n & edge_down(sck_d_r, sck);
  wire din_act = |(din ^ din_d_r);
  wire ref_rise = edge_up(ref_d_r, refclk);

  // ***********************************************
  // Shift register and bit counter
  // ***********************************************
  reg [15:0] shift_r;
  reg [`SSP_CNT_W-1:0] cnt_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      shift_r <= 16'h0000;
      cnt_r <= {`SSP_CNT_W{1'b0}};
    end
    else if (cs_fall)
    begin
      cnt_r <= {`SSP_CNT_W{1'b0}};
    end
    // Stray clocks outside a frame never get here, see sck_rise
    else if (sck_rise)
    begin
      shift_r <= {shift_r[14:0], sdi};
      // Saturates one past a frame, so an overlong frame never looks exact
      if (cnt_r <= `SSP_FRAME_LAST)
        cnt_r <= cnt_r + 5'h01;
      else
        cnt_r <= cnt_r;
    end
  end

  // Only an exact 16 bit frame is applied; partial ones are dropped
  wire frame_ok = cs_rise & (cnt_r == `SSP_FRAME_LAST);
  // Command sits in the top nibble of the captured word
  wire [3:0] cmd = shift_r[`SSP_CMD_HI:`SSP_CMD_LO];

  // ***********************************************
  // Serial output, daisy chain
  // ***********************************************
  // MSB leaves first, so bits pass through after 16 clocks
  // Driven only while selected, so a shared return line is left free
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      so_o <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      so_oe <= ~cs_n;
      if (cs_fall)
        so_o <= shift_r[15];
      else if (sck_fall)
        so_o <= shift_r[15];
    end
  end

  // ***********************************************
  // Configuration and mode state
  // ***********************************************
  reg [3:0] ch_on_r;
  reg [3:0] ch_en_r;
  reg ext_r;
  reg [2:0] sns_r;
  reg wdog_en_r;
  reg normal_r;
  reg asleep_r;
  reg [`SSP_WDOG_W-1:0] wdog_r;
  // Loss-of-link timer runs only once armed; any good frame restarts it
  wire wdog_exp = wdog_en_r & (wdog_r == `SSP_WDOG_CYCLES);
  always @(posedge clk)
  begin
    if (!nrst || !rst_pin_n)
    begin
      // Defaults and sleep
      ch_on_r <= 4'h0;
      ch_en_r <= 4'h0;
      ext_r <= 1'b0;
      sns_r <= `SSP_SNS_RST;
      wdog_en_r <= 1'b0;
      normal_r <= 1'b0;
      asleep_r <= 1'b1;
      wdog_r <= {`SSP_WDOG_W{1'b0}};
    end
    else
    begin
      if (din_act || cs_fall)
        asleep_r <= 1'b0;
      if (frame_ok)
        wdog_r <= {`SSP_WDOG_W{1'b0}};
      else if (wdog_en_r && !wdog_exp)
        wdog_r <= wdog_r + 32'h00000001;
      // Limp or lost link drops back to Fail; limp wins over any frame
      if (limp || wdog_exp)
        normal_r <= 1'b0;
      else if (frame_ok && cmd == `SSP_CMD_NORMAL)
        normal_r <= 1'b1;
      // A cut frame leaves the count short, so nothing below is applied
      if (frame_ok)
      begin
        case (cmd)
          `SSP_CMD_CHAN:
          begin
            ch_on_r <= shift_r[`SSP_CH_ON_LO+3:`SSP_CH_ON_LO];
            ch_en_r <= shift_r[`SSP_CH_EN_LO+3:`SSP_CH_EN_LO];
            ext_r <= shift_r[`SSP_CH_EXT];
          end
          `SSP_CMD_SENSE: sns_r <= shift_r[`SSP_SNS_HI:`SSP_SNS_LO];
          `SSP_CMD_WDOG: wdog_en_r <= shift_r[0];
          default: ;
        endcase
      end
    end
  end

  // ***********************************************
  // PWM prescaler, sense sync pulse
  // ***********************************************
  // Reference divider advances only in Normal mode; Fail keeps it frozen
  reg [`SSP_PWM_DIV_W-1:0] div_r;
  reg [3:0] sync_cnt_r;
  reg sense_set_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      div_r <= {`SSP_PWM_DIV_W{1'b0}};
      sync_cnt_r <= 4'h0;
      sense_set_r <= 1'b0;
    end
    else
    begin
      sense_set_r <= frame_ok & (cmd == `SSP_CMD_SENSE);
      if (normal_r && ref_rise)
        div_r <= div_r + 8'h01;
      if (sense_set_r)
        sync_cnt_r <= `SSP_SYNC_LEN;
      else if (sync_cnt_r != 4'h0)
        sync_cnt_r <= sync_cnt_r - 4'h1;
    end
  end

  // ***********************************************
  // Registered outputs
  // ***********************************************
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      chan_on <= 4'h0;
      ext_switch_out <= 1'b0;
      sense_out <= `SSP_SNS_RST;
      sense_sync_o <= 1'b0;
      sense_sync_oe <= 1'b0;
      pwm_tick <= 1'b0;
      fail_mode <= 1'b1;
      sleep_state <= 1'b1;
      clk_pin_o <= 1'b0;
      clk_pin_oe <= 1'b0;
    end
    else
    begin
      // Limitation: a direct input reaches the channels three cycles after the pin
      if (!normal_r)
        chan_on <= din;
      else
        chan_on <= ch_on_r | (din & ch_en_r);
      ext_switch_out <= ext_r;
      sense_out <= sns_r;
      sense_sync_o <= 1'b0;
      sense_sync_oe <= (sync_cnt_r != 4'h0);
      pwm_tick <= normal_r & ref_rise & (div_r == `SSP_PWM_DIV_LAST);
      fail_mode <= ~normal_r;
      sleep_state <= asleep_r;
      // Pin driven only while asleep so an awake device can take the reference
      clk_pin_o <= 1'b0;
      clk_pin_oe <= asleep_r;
    end
  end

endmodule // ssp_core

// *** core/ssp_sync2.v ***
// Two-flop synchroniser bank for pin inputs.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ns

module ssp_sync2
#(
  parameter W = 1
)
(
  input wire clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_r;

  // First stage is read only by second stage
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // ssp_sync2

// *** pkg/ssp_defines.vh ***
// Constants for the switch controller serial port block.
// Assumes inclusion by bare name from the core files.
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// ***********************************************
// Frame format
// ***********************************************
`define SSP_FRAME_BITS 16
`define SSP_CNT_W 5
`define SSP_FRAME_LAST 5'h10

// ***********************************************
// Command word fields (upper nibble is the command)
// ***********************************************
`define SSP_CMD_HI 15
`define SSP_CMD_LO 12
`define SSP_CMD_CHAN 4'h1
`define SSP_CMD_SENSE 4'h2
`define SSP_CMD_WDOG 4'h3
`define SSP_CMD_NORMAL 4'h4
// Channel word: bits 3:0 channel on, bits 7:4 direct-input enable, bit 8 ext switch
`define SSP_CH_ON_LO 0
`define SSP_CH_EN_LO 4
`define SSP_CH_EXT 8
// Sense word: bits 2:0 source select
`define SSP_SNS_HI 2
`define SSP_SNS_LO 0
`define SSP_SNS_RST 3'h0

// ***********************************************
// Timing
// ***********************************************
`define SSP_PWM_DIV_W 8
`define SSP_PWM_DIV_LAST 8'hFF
// Communication loss timeout in clk cycles (256 us at 250 MHz)
`define SSP_WDOG_CYCLES 32'h0000FA00
`define SSP_WDOG_W 32
// Sense sync low pulse length in clk cycles
`define SSP_SYNC_LEN 4'hF

`endif

// *** tb/ssp_chk.sv ***
// Checker for the serial port core: pin and mode outputs.
// Assumes binding onto ssp_core; pins pass two sync flops first.
`timescale 1ns/1ns
module ssp_chk
(
  input wire clk,
  input wire nrst,
  input wire reset_sleep_n,
  input wire chip_select_n,
  input wire direct_in_1,
  input wire direct_in_2,
  input wire direct_in_3,
  input wire direct_in_4,
  input wire limp_in,
  input wire so_oe,
  input wire clk_pin_o,
  input wire clk_pin_oe,
  input wire [3:0] chan_on,
  input wire sense_sync_o,
  input wire sense_sync_oe,
  input wire pwm_tick,
  input wire fail_mode,
  input wire sleep_state
);
  wire [3:0] din = {direct_in_4, direct_in_3, direct_in_2, direct_in_1};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Sync pulse held 15 cycles, then released
  sequence s_sync_hold;
    sense_sync_oe [*8] ##1 sense_sync_oe [*7];
  endsequence
  sequence s_sync_end;
    !sense_sync_oe;
  endsequence
  a_sync_len: assert property ($rose(sense_sync_oe) |-> s_sync_hold ##1 s_sync_end)
    else $error("sync pulse length wrong");
  a_sync_od: assert property (!sense_sync_o)
    else $error("sync pin driven high");
  a_so_release: assert property (chip_select_n [*6] |-> !so_oe)
    else $error("serial out driven while deselected");
  a_so_drive: assert property ((reset_sleep_n && !chip_select_n) [*6] |-> so_oe)
    else $error("serial out not driven while selected");
  a_clk_low: assert property (clk_pin_oe |-> !clk_pin_o)
    else $error("clock pin driven high");
  a_clk_awake: assert property (!sleep_state [*2] |-> !clk_pin_oe)
    else $error("clock pin held while awake");
  a_tick_pulse: assert property (pwm_tick |=> !pwm_tick [*8])
    else $error("pwm tick too close");
  a_limp_fail: assert property (limp_in [*5] |-> fail_mode)
    else $error("limp did not force fail mode");
  // Slack of six cycles covers the input synchronisers
  a_fail_follow: assert property ((fail_mode && reset_sleep_n && !sleep_state
    && $stable(din)) [*6] |-> chan_on == din)
    else $error("channels not following inputs");
endmodule // ssp_chk

bind ssp_core ssp_chk i_ssp_chk (.*);

// *** tb/ssp_core_tb.sv ***
// Bench for the serial port core: master model plus pin stimulus.
// Assumes core, checker and master model are compiled first.
`timescale 1ns/1ns
module ssp_core_tb;
  logic clk, nrst, rsn, limp, ref_clk, csn, sclk, si, so_o, so_oe;
  logic cpo, cpoe, ext, syo, syoe, tick, fail, slp;
  logic [3:0] din, chan_on;
  logic [2:0] sense;
  int err_count = 0;
  int total_checks = 0;
  int ticks;
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Clock pin resolves to the device's pull-low while it drives
  ssp_core i_ssp_core (.clk(clk), .nrst(nrst), .reset_sleep_n(rsn), .chip_select_n(csn),
    .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe), .direct_in_1(din[0]),
    .direct_in_2(din[1]), .direct_in_3(din[2]), .direct_in_4(din[3]), .limp_in(limp),
    .clk_pin_i(cpoe ? cpo : ref_clk), .clk_pin_o(cpo), .clk_pin_oe(cpoe), .chan_on(chan_on),
    .ext_switch_out(ext), .sense_out(sense), .sense_sync_o(syo), .sense_sync_oe(syoe),
    .pwm_tick(tick), .fail_mode(fail), .sleep_state(slp));
  ssp_master i_ssp_master (.clk(clk), .so_o(so_o), .so_oe(so_oe), .chip_select_n(csn),
    .sclk(sclk), .si(si));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic fr(input logic [31:0] w, input int n);
    i_ssp_master.xfer(w, n);
    repeat (10) @(negedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic sc_normal;
    fr(32'h4000, 16);
    fr(32'h1105, 16);
    chk("fail", 0, fail);
    chk("clkoe", 0, cpoe);
    chk("chan", 4'h5, chan_on);
    chk("ext", 1, ext);
    chk("so_oe", 0, so_oe);
    fr(32'h10F0, 16);
    din = 4'hA;
    repeat (8) @(negedge clk);
    chk("chan", 4'hA, chan_on);
    fr(32'h1003, 15);
    chk("chan", 4'hA, chan_on);
  endtask
  task automatic sc_sense;
    i_ssp_master.xfer(32'h2005, 16);
    ticks = 0;
    repeat (30) @(negedge clk) ticks += syoe;
    chk("sync", 15, ticks);
    chk("sense", 3'h5, sense);
    i_ssp_master.xfer(32'hA5C3A5C3, 32);
    chk("so_old", 16'h2005, i_ssp_master.rx[31:16]);
    chk("so", 16'hA5C3, i_ssp_master.rx[15:0]);
  endtask
  task automatic sc_limp;
    limp = 1'b1;
    din = 4'h6;
    repeat (10) @(negedge clk);
    chk("fail", 1, fail);
    chk("chan", 4'h6, chan_on);
    // Reference edges in Fail mode must not reach the PWM timebase
    ticks = 0;
    repeat (600)
    begin
      repeat (4) @(negedge clk) ticks += tick;
      ref_clk = ~ref_clk;
    end
    chk("ticks", 0, ticks);
    limp = 1'b0;
    rsn = 1'b0;
    repeat (10) @(negedge clk);
    chk("sleep", 1, slp);
    chk("clkoe", 1, cpoe);
    rsn = 1'b1;
    repeat (5) @(negedge clk);
    din = 4'h1;
    repeat (10) @(negedge clk);
    chk("sleep", 0, slp);
  endtask
  // Two full divider periods whatever the starting phase
  task automatic sc_pwm;
    fr(32'h4000, 16);
    ticks = 0;
    repeat (1024)
    begin
      repeat (4) @(negedge clk) ticks += tick;
      ref_clk = ~ref_clk;
    end
    chk("ticks", 2, ticks);
  endtask
  task automatic sc_wdog;
    fr(32'h3001, 16);
    chk("fail", 0, fail);
    din = 4'h9;
    repeat (64100) @(negedge clk);
    chk("fail", 1, fail);
    chk("chan", 4'h9, chan_on);
  endtask
  initial
  begin
    nrst = 1'b0;
    rsn = 1'b1;
    din = 4'h0;
    limp = 1'b0;
    ref_clk = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("fail", 1, fail);
    chk("sleep", 1, slp);
    sc_normal;
    sc_sense;
    sc_limp;
    sc_pwm;
    sc_wdog;
    summarize;
  end
  // Watchdog: whole run is about 80500 cycles, 100000 cycles gives room
  initial
  begin
    #400000;
    err_count++;
    summarize;
  end
endmodule // ssp_core_tb

// *** tb/ssp_master.sv ***
// Master model driving frames of n bits on the serial port.
// Assumes the bench clock; sclk half period 120 ns, under 5 MHz.
`timescale 1ns/1ns
module ssp_master
(
  input wire clk,
  input wire so_o,
  input wire so_oe,
  output logic chip_select_n,
  output logic sclk,
  output logic si
);
  logic [31:0] rx;
  initial
  begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // Stray clocks while deselected must be ignored; MSB first
  task automatic xfer(input logic [31:0] w, input int n);
    rx = 32'h0;
    repeat (4) #120 sclk = ~sclk;
    chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      si = w[i];
      #120 sclk = 1'b1;
      rx = {rx[30:0], so_oe ? so_o : ~rx[0]};
      #120 sclk = 1'b0;
    end
    #120 chip_select_n = 1'b1;
    si = ~si;
  endtask
endmodule // ssp_master
